// ==== inc/sdf_map.svh ====
// clock rate, ratios, widths and timing counts of the decimation filter
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH
`define SDF_CLK_SYS_HZ       20000000
`define SDF_POWERUP_WAIT_US  600
`define SDF_POWERUP_CYCLES   ((`SDF_POWERUP_WAIT_US * (`SDF_CLK_SYS_HZ / 1000000)))
`define SDF_OSR_DEFAULT      256
`define SDF_OSR_MIN          16
`define SDF_OUT_WIDTH        16
`define SDF_CHANNELS         4
`define SDF_SINC3_SETTLE     3
`define SDF_SINC2_SETTLE     2
`define SDF_FAST_SETTLE      4
`define SDF_EXT_HALF_CYC     2
`endif

// ==== inc/sdf_pkg.sv ====
// types of the decimation filter
package sdf_pkg;
  typedef enum logic [1:0] {
    SDF_MODE_SINC3,
    SDF_MODE_SINC2,
    SDF_MODE_FAST
  } sdf_mode_t;
  typedef enum logic [1:0] {
    SDF_ST_POWERUP,
    SDF_ST_SETTLE,
    SDF_ST_RUN
  } sdf_state_t;
endpackage

// ==== rtl/sdf_word_mem.sv ====
// small memory holding the previous decimated words for the fast mode
`timescale 1ns/1ps
module sdf_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule // sdf_word_mem

// ==== rtl/sdf_decim_host.sv ====
// four-channel sinc decimation filter receiving modulator bitstreams
`timescale 1ns/1ps
`include "sdf_map.svh"
// Notes on behaviour
// - sinc3 filter turns bitstream into word
// - ratio supports 16 to 256
// - 16-bit word at ratio 256
// - one word per ratio modulator clocks
// - minus 3 dB at quarter data rate
// - sinc3 settles three, sinc2 two clocks
// - data clock is modulator clock over ratio
// - fast mode: sinc2 times (1+z^-2R)
// - cascade low-ratio sinc3 then second stage (not built: a single sinc stage per mode)
// - fast low-order path for overcurrent
// - external clock held static on internal osc
// - wait 600 us before using outputs
module sdf_decim_host import sdf_pkg::*; #(
  parameter int OVERSAMPLING_RATIO        = `SDF_OSR_DEFAULT,
  parameter int OUT_W      = `SDF_OUT_WIDTH,
  parameter int NCH        = `SDF_CHANNELS,
  parameter int WAIT_CYC   = `SDF_POWERUP_CYCLES,
  parameter int ACC_W      = 3 * $clog2(OVERSAMPLING_RATIO) + 1
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               modulator_clock_out,
  input  wire logic [NCH-1:0]     channel_bitstream_out,
  input  wire logic               use_internal_osc,
  input  wire sdf_mode_t          filter_mode,
  output logic                    clock_source_select,
  output logic                    external_clock_input,
  output logic                    external_clock_input_oe,
  output logic [NCH*OUT_W-1:0]    data_word,
  output logic                    data_valid,
  output logic                    data_settled,
  output logic                    powerup_done
);
  localparam int CW = $clog2(OVERSAMPLING_RATIO);
  localparam int CHW = $clog2(NCH);
  localparam int WC_W = $clog2(WAIT_CYC + 1);
  // full scale of sinc3 is OVERSAMPLING_RATIO^3, needs ACC_W bits; words keep top OUT_W
  localparam int SHIFT = (ACC_W > OUT_W) ? ACC_W - OUT_W : 0;

  // clock select strap; external clock held static only on the internal oscillator
  logic osc_sel_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) osc_sel_reg <= 1'b1;
    else        osc_sel_reg <= use_internal_osc;
  end
  // divided clock for the external input, parked low on the internal oscillator
  localparam int EXT_HALF = `SDF_EXT_HALF_CYC;
  localparam int EDW      = $clog2(EXT_HALF + 1);
  logic [EDW-1:0] ext_div_reg;
  logic           ext_clk_reg;
  wire            ext_half_done = (ext_div_reg == EDW'(EXT_HALF - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_div_reg <= '0;
      ext_clk_reg <= 1'b0;
    end else if (use_internal_osc) begin
      ext_div_reg <= '0;
      ext_clk_reg <= 1'b0;
    end else if (ext_half_done) begin
      ext_div_reg <= '0;
      ext_clk_reg <= ~ext_clk_reg;
    end else begin
      ext_div_reg <= ext_div_reg + 1'b1;
    end
  end
  assign clock_source_select     = osc_sel_reg;
  assign external_clock_input    = ext_clk_reg;
  assign external_clock_input_oe = 1'b1;

  // power-up wait before trusting the modulator
  sdf_state_t       state_reg, state_next;
  logic [WC_W-1:0]  wait_cnt_reg;
  wire              wait_over = (wait_cnt_reg == WC_W'(WAIT_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wait_cnt_reg <= '0;
    else if (state_reg == SDF_ST_POWERUP && !wait_over) wait_cnt_reg <= wait_cnt_reg + 1'b1;
  end
  assign powerup_done = (state_reg != SDF_ST_POWERUP);

  // synchronisers for link clock and bitstreams
  logic           mclk_s1_reg, mclk_s2_reg, mclk_s3_reg;
  logic [NCH-1:0] bit_s1_reg, bit_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
      bit_s1_reg  <= '0;
      bit_s2_reg  <= '0;
    end else begin
      mclk_s1_reg <= modulator_clock_out;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
      bit_s1_reg  <= channel_bitstream_out;
      bit_s2_reg  <= bit_s1_reg;
    end
  end
  // one sample per modulator clock, on its rising edge
  wire mod_tick = mclk_s2_reg & ~mclk_s3_reg & powerup_done;

  // data clock: modulator clock divided by ratio
  logic [CW-1:0] dec_cnt_reg;
  wire           dec_tick = mod_tick && (dec_cnt_reg == CW'(OVERSAMPLING_RATIO - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)        dec_cnt_reg <= '0;
    else if (dec_tick) dec_cnt_reg <= '0;
    else if (mod_tick) dec_cnt_reg <= dec_cnt_reg + 1'b1;
  end

  // integrators and differentiators, modular width
  logic [ACC_W-1:0] int1_reg [NCH];
  logic [ACC_W-1:0] int2_reg [NCH];
  logic [ACC_W-1:0] int3_reg [NCH];
  logic [ACC_W-1:0] d1_reg   [NCH];
  logic [ACC_W-1:0] d2_reg   [NCH];
  logic [ACC_W-1:0] d3_reg   [NCH];
  logic [ACC_W-1:0] comb1    [NCH];
  logic [ACC_W-1:0] comb2    [NCH];
  logic [ACC_W-1:0] comb3    [NCH];
  logic [ACC_W-1:0] sinc2_in [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          int1_reg[g] <= '0;
          int2_reg[g] <= '0;
          int3_reg[g] <= '0;
        end else if (mod_tick) begin
          int1_reg[g] <= int1_reg[g] + ACC_W'(bit_s2_reg[g]);
          int2_reg[g] <= int2_reg[g] + int1_reg[g];
          int3_reg[g] <= int3_reg[g] + int2_reg[g];
        end
      end
      // sinc2 uses second integrator, sinc3 the third
      assign sinc2_in[g] = (filter_mode == SDF_MODE_SINC3) ? int3_reg[g] : int2_reg[g];
      assign comb1[g] = sinc2_in[g] - d1_reg[g];
      assign comb2[g] = comb1[g] - d2_reg[g];
      assign comb3[g] = comb2[g] - d3_reg[g];
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          d1_reg[g] <= '0;
          d2_reg[g] <= '0;
          d3_reg[g] <= '0;
        end else if (dec_tick) begin
          d1_reg[g] <= sinc2_in[g];
          d2_reg[g] <= comb1[g];
          d3_reg[g] <= comb2[g];
        end
      end
    end
  endgenerate

  // sinc output before fast-mode sum
  function automatic logic [ACC_W-1:0] stage_out(input sdf_mode_t m,
                                                 input logic [ACC_W-1:0] c2,
                                                 input logic [ACC_W-1:0] c3);
    stage_out = (m == SDF_MODE_SINC3) ? c3 : c2;
  endfunction

  // fast mode keeps two words per channel and adds the one from two data clocks back
  localparam int MAW = $clog2(NCH * 2);
  logic [0:0]        slot_reg;
  logic [CHW-1:0]    ch_reg;
  logic [ACC_W-1:0]  hist_rd;
  logic              scan_reg;
  logic [ACC_W-1:0]  cur_word [NCH];
  logic [ACC_W-1:0]  cur_hold_reg [NCH];
  generate
    for (g = 0; g < NCH; g++) begin : g_out
      assign cur_word[g] = stage_out(filter_mode, comb2[g], comb3[g]);
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)        cur_hold_reg[g] <= '0;
        else if (dec_tick) cur_hold_reg[g] <= cur_word[g];
      end
    end
  endgenerate

  // history slot read one cycle ahead of its use, written after
  wire [MAW-1:0] hist_addr = MAW'({ch_reg, slot_reg});
  logic scan_d_reg;
  logic [CHW-1:0] ch_d_reg;
  sdf_word_mem #(
    .WIDTH (ACC_W),
    .DEPTH (NCH * 2),
    .AW    (MAW)
  ) i_sdf_word_mem (
    .clk_sys (clk_sys),
    .wr_en   (scan_d_reg),
    .wr_addr (MAW'({ch_d_reg, slot_reg})),
    .wr_data (cur_hold_reg[ch_d_reg]),
    .rd_addr (hist_addr),
    .rd_data (hist_rd)
  );

  // scan the channels after each data clock, then emit the word
  wire scan_last = scan_d_reg && (ch_d_reg == CHW'(NCH - 1));
  wire scan_end  = scan_reg && (ch_reg == CHW'(NCH - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scan_d_reg <= 1'b0;
      ch_d_reg   <= '0;
    end else begin
      scan_d_reg <= scan_reg;
      ch_d_reg   <= ch_reg;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scan_reg <= 1'b0;
      ch_reg   <= '0;
    end else if (dec_tick) begin
      scan_reg <= 1'b1;
      ch_reg   <= '0;
    end else if (scan_end) begin
      scan_reg <= 1'b0;
    end else if (scan_reg) begin
      ch_reg <= ch_reg + 1'b1;
    end
  end
  // slot flips after the last channel is written, so reads see two clocks back
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)         slot_reg <= '0;
    else if (scan_last) slot_reg <= ~slot_reg;
  end

  // (1 + z^-2R) sum, scaled to the output word
  wire [ACC_W-1:0] fast_sum = cur_hold_reg[ch_d_reg] + hist_rd;
  wire [ACC_W-1:0] sel_word = (filter_mode == SDF_MODE_FAST) ? fast_sum
                                                             : cur_hold_reg[ch_d_reg];
  wire [OUT_W-1:0] scaled   = OUT_W'(sel_word >> SHIFT);

  // settling: count data clocks since start or mode change
  sdf_mode_t  mode_reg;
  logic [2:0] settle_cnt_reg;
  wire  [2:0] settle_need = (filter_mode == SDF_MODE_SINC3) ? 3'(`SDF_SINC3_SETTLE) :
                            (filter_mode == SDF_MODE_SINC2) ? 3'(`SDF_SINC2_SETTLE) :
                                                              3'(`SDF_FAST_SETTLE);
  wire        mode_chg = (mode_reg != filter_mode);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg       <= SDF_MODE_SINC3;
      settle_cnt_reg <= '0;
    end else begin
      mode_reg <= filter_mode;
      if (mode_chg) settle_cnt_reg <= '0;
      else if (dec_tick && settle_cnt_reg != settle_need) settle_cnt_reg <= settle_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SDF_ST_POWERUP: if (wait_over) state_next = SDF_ST_SETTLE;
      SDF_ST_SETTLE:  if (settle_cnt_reg == settle_need && !mode_chg) state_next = SDF_ST_RUN;
      SDF_ST_RUN:     if (mode_chg) state_next = SDF_ST_SETTLE;
      default:        state_next = SDF_ST_POWERUP;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) state_reg <= SDF_ST_POWERUP;
    else        state_reg <= state_next;
  end
  assign data_settled = (state_reg == SDF_ST_RUN);

  // output words and valid pulse once per data clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_word  <= '0;
      data_valid <= 1'b0;
    end else begin
      data_valid <= scan_last;
      if (scan_d_reg) data_word[ch_d_reg*OUT_W +: OUT_W] <= scaled;
    end
  end
endmodule // sdf_decim_host

// ==== dv/sdf_decim_host_properties.sv ====
// concurrent checks on the decimation filter ports
`timescale 1ns/1ps
module sdf_decim_host_chk import sdf_pkg::*; #(
  parameter int OVERSAMPLING_RATIO      = 256,
  parameter int WAIT_CYC = 12000
) (
  input wire logic      clk_sys,
  input wire logic      rst_b,
  input wire logic      modulator_clock_out,
  input wire logic      use_internal_osc,
  input wire sdf_mode_t filter_mode,
  input wire logic      clock_source_select,
  input wire logic      external_clock_input,
  input wire logic      external_clock_input_oe,
  input wire logic      data_valid,
  input wire logic      data_settled,
  input wire logic      powerup_done
);
  logic      mc_reg;
  logic      seen_reg;
  int        rise_reg;
  int        cyc_reg;
  wire logic rise = modulator_clock_out && !mc_reg;
  // rises counted per word window; check resumes only after the first word that follows a mode change
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mc_reg   <= 1'b0;
      seen_reg <= 1'b0;
      rise_reg <= 0;
      cyc_reg  <= 0;
    end else begin
      mc_reg   <= modulator_clock_out;
      seen_reg <= (seen_reg || data_valid) && !$changed(filter_mode);
      rise_reg <= data_valid ? int'(rise) : rise_reg + int'(rise);
      cyc_reg  <= powerup_done ? cyc_reg : cyc_reg + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_gap;
    !data_valid [*8];
  endsequence
  sequence s_unsettled;
    ##[1:2] !data_settled;
  endsequence
  a_valid_pulse: assert property (data_valid |=> s_gap)
    else $error("word strobe too long or too close");
  a_word_rate: assert property (data_valid && seen_reg |-> rise_reg == OVERSAMPLING_RATIO)
    else $error("word not one per ratio modulator clocks");
  a_valid_gated: assert property (data_valid |-> powerup_done)
    else $error("word before power-up wait");
  a_done_sticky: assert property (powerup_done |=> powerup_done)
    else $error("power-up flag dropped");
  a_wait_length: assert property ($rose(powerup_done) |->
    cyc_reg >= WAIT_CYC - 1 && cyc_reg <= WAIT_CYC + 2)
    else $error("power-up wait wrong length");
  a_settle_gated: assert property (data_settled |-> powerup_done)
    else $error("settled before power-up");
  a_settle_restart: assert property ($changed(filter_mode) |-> s_unsettled)
    else $error("settling not restarted");
  a_ext_static: assert property (clock_source_select |->
    external_clock_input_oe && !external_clock_input && $stable(external_clock_input))
    else $error("external clock not held static");
  a_select_follow: assert property ($changed(use_internal_osc) |->
    ##[1:2] clock_source_select == use_internal_osc)
    else $error("clock select strap not following");
  a_ext_clock_runs: assert property (!clock_source_select && !use_internal_osc |->
    ##[1:2] $changed(external_clock_input))
    else $error("external clock not running");
endmodule // sdf_decim_host_chk

bind sdf_decim_host sdf_decim_host_chk #(.OVERSAMPLING_RATIO(OVERSAMPLING_RATIO), .WAIT_CYC(WAIT_CYC)) i_sdf_decim_host_chk (
  .clk_sys, .rst_b, .modulator_clock_out, .use_internal_osc, .filter_mode,
  .clock_source_select, .external_clock_input, .external_clock_input_oe,
  .data_valid, .data_settled, .powerup_done);

// ==== dv/sdf_mod_model.sv ====
// behavioural four-channel modulator: bitstreams and one common clock
`timescale 1ns/1ps
module sdf_mod_model (
  input  wire logic       clock_source_select,
  input  wire logic       external_clock_input,
  input  wire logic [7:0] pat,
  output logic            modulator_clock_out,
  output logic [3:0]      channel_bitstream_out
);
  logic tog = 1'b0;
  initial modulator_clock_out = 1'b0;
  // internal oscillator scaled to the bench rate; external input halved
  always begin // one clock shared by all channels
    if (clock_source_select !== 1'b0) #200 modulator_clock_out = ~modulator_clock_out;
    else begin
      @(posedge external_clock_input or posedge clock_source_select);
      modulator_clock_out = ~modulator_clock_out;
    end
  end
  // code 0 no ones, 1 all ones, 2 half ones; bits move on the falling edge
  always @(negedge modulator_clock_out) begin
    tog = ~tog;
    for (int k = 0; k < 4; k++)
      channel_bitstream_out[k] = pat[2*k+:2] == 2'h1 || (pat[2*k+:2] == 2'h2 && tog);
  end
endmodule // sdf_mod_model

// ==== dv/test_sdf_decim_host.sv ====
// self-checking bench of the four-channel decimation filter
`timescale 1ns/1ps
module test_sdf_decim_host import sdf_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        use_internal_osc = 1'b1;
  logic [7:0]  pat = 8'h00;
  sdf_mode_t   filter_mode = SDF_MODE_SINC3;
  logic        modulator_clock_out;
  logic [3:0]  channel_bitstream_out;
  logic        clock_source_select;
  logic        external_clock_input;
  logic        external_clock_input_oe;
  logic [63:0] data_word;
  logic        data_valid;
  logic        data_settled;
  logic        powerup_done;
  int          failures = 0;
  int          total_checks = 0;
  logic [63:0] exp_q[$];
  always #25 clk_sys = ~clk_sys;
  sdf_decim_host #(.OVERSAMPLING_RATIO(64), .WAIT_CYC(20)) i_sdf_decim_host (.clk_sys, .rst_b,
    .modulator_clock_out, .channel_bitstream_out, .use_internal_osc, .filter_mode,
    .clock_source_select, .external_clock_input, .external_clock_input_oe,
    .data_word, .data_valid, .data_settled, .powerup_done);
  sdf_mod_model i_sdf_mod_model (.clock_source_select, .external_clock_input, .pat,
    .modulator_clock_out, .channel_bitstream_out);
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_valids(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (data_valid !== 1'b1 && k < 9000) begin
        @(negedge clk_sys);
        k++;
      end
      if (k >= 9000) failures++;
      if (k >= 9000) wrap_up();
      @(negedge clk_sys);
    end
  endtask
  // settled words at ratio 64: top 16 of 19 accumulator bits
  function automatic logic [63:0] word_of(sdf_mode_t m, logic [7:0] p);
    logic [15:0] fs;
    fs = m == SDF_MODE_SINC3 ? 16'h8000 : m == SDF_MODE_SINC2 ? 16'h0200 : 16'h0400;
    for (int k = 0; k < 4; k++)
      word_of[16*k+:16] = p[2*k+:2] == 2'h1 ? fs : p[2*k+:2] == 2'h2 ? fs >> 1 : 16'h0000;
  endfunction
  always @(negedge clk_sys) begin
    if (data_valid === 1'b1 && exp_q.size() > 0)
      check("data_word", data_word, exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'hB17DF19C));
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    check("clock_source_select", clock_source_select, 64'h1);
    for (int m = 0; m < 3; m++) begin
      filter_mode = sdf_mode_t'(m);
      repeat (3) @(negedge clk_sys);
      check("data_settled", data_settled, 64'h0);
      wait_valids(m == 1 ? 3 : m == 0 ? 4 : 5);
      check("data_settled", data_settled, 64'h1);
      for (int r = 0; r < 3; r++) begin
        pat = 8'h55;
        if (r > 0) for (int k = 0; k < 4; k++) pat[2*k+:2] = 2'($urandom_range(2));
        wait_valids(5);
        exp_q.push_back(word_of(filter_mode, pat));
        wait_valids(1);
      end
    end
    use_internal_osc = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("clock_source_select", clock_source_select, 64'h0);
    // words keep coming on the divided external clock
    wait_valids(5);
    exp_q.push_back(word_of(filter_mode, pat));
    wait_valids(1);
    wrap_up();
  end
endmodule // test_sdf_decim_host
